// ===== lpcal_defs.vh
// Purpose: constants for the low-power calibration scheduler and vector port
// Assumes: byte-wide register port, 7-bit addresses
// Notes: offsets are byte addresses on the register port
`ifndef LPCAL_DEFS_VH
`define LPCAL_DEFS_VH
`define LPCAL_OFS_LP_CTRL 7'h6E
`define LPCAL_OFS_VEC_EN 7'h70
`define LPCAL_OFS_VEC_PORT 7'h71
`define LPCAL_OFS_PIN_CFG 7'h6B
`define LPCAL_OFS_SOFT_TRIG 7'h6C
`define LPCAL_OFS_STATUS 7'h6A
`define LPCAL_RST_LP_CTRL 8'h88
`define LPCAL_RST_VEC_EN 8'h00
`define LPCAL_RST_PIN_CFG 8'h00
`define LPCAL_RST_SOFT_TRIG 8'h01
`define LPCAL_SLEEP_MSB 7
`define LPCAL_SLEEP_LSB 5
`define LPCAL_WAKE_MSB 4
`define LPCAL_WAKE_LSB 3
`define LPCAL_TRIG_BIT 1
`define LPCAL_EN_BIT 0
`define LPCAL_STOPPED_BIT 1
`define LPCAL_VEC_LEN 673
`define LPCAL_TICK_SHIFT 8
`define LPCAL_SLEEP_K0 6'h03
`define LPCAL_SLEEP_K1 6'h0F
`define LPCAL_SLEEP_K2 6'h12
`define LPCAL_SLEEP_K3 6'h12
`define LPCAL_SLEEP_K4 6'h15
`define LPCAL_SLEEP_K5 6'h1B
`define LPCAL_SLEEP_K6 6'h1E
`define LPCAL_SLEEP_K7 6'h21
`define LPCAL_WAKE_K0 6'h03
`define LPCAL_WAKE_K1 6'h12
`define LPCAL_WAKE_K2 6'h15
`define LPCAL_WAKE_K3 6'h18
`endif

// ===== lpcal_sched.v
// Purpose: low-power calibration scheduler and calibration vector port
// Assumes: host keeps sleep code >= 4, wake code >= 1, full 673 transfers
// Notes: one clock; delays counted in sample-clock periods of clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "lpcal_defs.vh"
module lpcal_sched #(
    parameter VEC_LEN = `LPCAL_VEC_LEN
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire [6:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire background_calib_enable,
    input wire calib_halted,
    input wire calib_trigger_pin,
    input wire [7:0] vec_rdata,
    output wire [9:0] vec_index,
    output wire vec_we,
    output wire [7:0] vec_wdata,
    output wire vec_valid,
    output wire core_sleep,
    output wire core_settling,
    output wire calib_start
);
    ////////////////////////////////////////////////////////////////////////
    // scheduler states
    localparam ST_IDLE = 2'h0;
    localparam ST_SLEEP = 2'h1;
    localparam ST_WAKE = 2'h2;
    localparam ST_CAL = 2'h3;
    ////////////////////////////////////////////////////////////////////////
    // clocks for exponent k: (2^k + 1) periods of 256
    function [41:0] delay_of;
        input [5:0] k;
        begin
            delay_of = ((42'h1 << k) + 42'h1) << `LPCAL_TICK_SHIFT;
        end
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // registers, counters and field decode
    reg [7:0] lp_ctrl_q;
    reg [7:0] vec_en_q;
    reg [7:0] pin_cfg_q;
    reg [7:0] soft_trig_q;
    reg [9:0] idx_q;
    reg valid_q;
    reg [1:0] st_q;
    reg [41:0] cnt_q;
    reg start_q;
    reg [2:0] pin_sync_q;
    reg trig_q;
    reg [5:0] sleep_k;
    reg [5:0] wake_k;
    wire port_hit = (reg_addr == `LPCAL_OFS_VEC_PORT) && vec_en_q[0];
    wire lp_on = lp_ctrl_q[`LPCAL_EN_BIT] && background_calib_enable;
    wire trig_mode = lp_ctrl_q[`LPCAL_TRIG_BIT];
    wire trig_level = pin_cfg_q[0] ? trig_q : soft_trig_q[0];
    wire [2:0] sleep_code = lp_ctrl_q[`LPCAL_SLEEP_MSB:`LPCAL_SLEEP_LSB];
    wire [1:0] wake_code = lp_ctrl_q[`LPCAL_WAKE_MSB:`LPCAL_WAKE_LSB];
    ////////////////////////////////////////////////////////////////////////
    // delay exponents
    always @* begin
        case (sleep_code)
            3'h0: sleep_k = `LPCAL_SLEEP_K0;
            3'h1: sleep_k = `LPCAL_SLEEP_K1;
            3'h2: sleep_k = `LPCAL_SLEEP_K2;
            3'h3: sleep_k = `LPCAL_SLEEP_K3;
            3'h4: sleep_k = `LPCAL_SLEEP_K4;
            3'h5: sleep_k = `LPCAL_SLEEP_K5;
            3'h6: sleep_k = `LPCAL_SLEEP_K6;
            default: sleep_k = `LPCAL_SLEEP_K7;
        endcase
        case (wake_code)
            2'h0: wake_k = `LPCAL_WAKE_K0;
            2'h1: wake_k = `LPCAL_WAKE_K1;
            2'h2: wake_k = `LPCAL_WAKE_K2;
            default: wake_k = `LPCAL_WAKE_K3;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    // trigger pin synchroniser, change counts once stages two and three agree
    // reset loads the idle high level, so no false wake follows reset
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_sync_q <= 3'h7;
            trig_q <= 1'b1;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], calib_trigger_pin};
            if (pin_sync_q[1] == pin_sync_q[2])
                trig_q <= pin_sync_q[2];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // registers and vector port
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            lp_ctrl_q <= `LPCAL_RST_LP_CTRL;
            vec_en_q <= `LPCAL_RST_VEC_EN;
            pin_cfg_q <= `LPCAL_RST_PIN_CFG;
            soft_trig_q <= `LPCAL_RST_SOFT_TRIG;
            idx_q <= 10'h000;
            valid_q <= 1'b1;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `LPCAL_OFS_LP_CTRL: lp_ctrl_q <= reg_wdata;
                    `LPCAL_OFS_PIN_CFG: pin_cfg_q <= reg_wdata;
                    `LPCAL_OFS_SOFT_TRIG: soft_trig_q <= reg_wdata;
                    `LPCAL_OFS_VEC_EN: begin
                        vec_en_q <= reg_wdata;
                        if (reg_wdata[0])
                            idx_q <= 10'h000;
                    end
                    default: ;
                endcase
            end
            if ((reg_wr || reg_rd) && port_hit) begin
                if (idx_q == VEC_LEN[9:0] - 10'h001) begin
                    idx_q <= 10'h000;
                    valid_q <= 1'b1;
                end else begin
                    idx_q <= idx_q + 10'h001;
                    valid_q <= 1'b0;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // vector store side
    assign vec_index = idx_q;
    assign vec_we = reg_wr && port_hit;
    assign vec_wdata = reg_wdata;
    assign vec_valid = valid_q;
    ////////////////////////////////////////////////////////////////////////
    // read-back mux, reserved bit 2 of the control reads zero
    always @* begin
        case (reg_addr)
            `LPCAL_OFS_LP_CTRL: reg_rdata = {lp_ctrl_q[7:3], 1'b0,
                lp_ctrl_q[1:0]};
            `LPCAL_OFS_VEC_EN: reg_rdata = vec_en_q;
            `LPCAL_OFS_PIN_CFG: reg_rdata = pin_cfg_q;
            `LPCAL_OFS_SOFT_TRIG: reg_rdata = soft_trig_q;
            `LPCAL_OFS_STATUS: reg_rdata = {6'h00, calib_halted, 1'b0};
            `LPCAL_OFS_VEC_PORT: reg_rdata = vec_en_q[0] ? vec_rdata
                : 8'h00;
            default: reg_rdata = 8'h00;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    // sleep / wake scheduler
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
            cnt_q <= 42'h0;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    cnt_q <= 42'h0;
                    if (lp_on)
                        st_q <= ST_SLEEP;
                end
                ST_SLEEP: begin
                    cnt_q <= cnt_q + 42'h1;
                    if (!lp_on) begin
                        st_q <= ST_IDLE;
                    end else if (trig_mode ? !trig_level
                            : (cnt_q >= delay_of(sleep_k) - 42'h1)) begin
                        st_q <= ST_WAKE;
                        cnt_q <= 42'h0;
                    end
                end
                ST_WAKE: begin
                    cnt_q <= cnt_q + 42'h1;
                    if (!lp_on) begin
                        st_q <= ST_IDLE;
                    end else if (cnt_q >= delay_of(wake_k) - 42'h1) begin
                        st_q <= ST_CAL;
                        start_q <= 1'b1;
                        cnt_q <= 42'h0;
                    end
                end
                ST_CAL: begin
                    cnt_q <= 42'h0;
                    st_q <= lp_on ? ST_SLEEP : ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    // scheduler outputs
    assign core_sleep = (st_q == ST_SLEEP);
    assign core_settling = (st_q == ST_WAKE);
    assign calib_start = start_q;
endmodule // lpcal_sched
`default_nettype wire

// ===== lpcal_checker.sv
// Purpose: port checks for lpcal_sched
// Assumes: vector enable tracked from host writes
// Notes: bound at file foot
`timescale 1ns/1ps
`default_nettype none
module lpcal_checker #(
    parameter VEC_LEN = 673
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] vec_rdata,
    input wire logic [9:0] vec_index,
    input wire logic vec_we,
    input wire logic [7:0] vec_wdata,
    input wire logic vec_valid,
    input wire logic calib_start
);
logic en_q;
wire acc = (reg_rd | reg_wr) && reg_addr == 7'h71 && en_q;
wire last = vec_index == 10'(VEC_LEN - 1);
always @(posedge clk_sys) begin
    if (sys_rst) en_q <= 1'b0;
    else if (reg_wr && reg_addr == 7'h70) en_q <= reg_wdata[0];
end
default clocking @(posedge clk_sys); endclocking
default disable iff (sys_rst);
property p_we; vec_we |-> acc && reg_wr && vec_wdata == reg_wdata; endproperty
a_we: assert property (p_we) else $error("bad vector write");
property p_rd; reg_rd && acc |-> reg_rdata == vec_rdata; endproperty
a_rd: assert property (p_rd) else $error("bad vector read");
property p_off; reg_addr == 7'h71 && !en_q |-> reg_rdata == 8'h00 && !vec_we;
endproperty
a_off: assert property (p_off) else $error("port open when off");
property p_step; acc && !last |=> vec_index == $past(vec_index) + 10'h001;
endproperty
a_step: assert property (p_step) else $error("index no step");
property p_wrap; acc && last |=> vec_index == 10'h000 && vec_valid; endproperty
a_wrap: assert property (p_wrap) else $error("bad wrap");
property p_part; acc && vec_index == 10'h000 |=> !vec_valid; endproperty
a_part: assert property (p_part) else $error("partial valid");
property p_irst; reg_wr && reg_addr == 7'h70 && reg_wdata[0] |=>
    vec_index == 10'h000; endproperty
a_irst: assert property (p_irst) else $error("index not reset");
property p_start; calib_start |=> !calib_start; endproperty
a_start: assert property (p_start) else $error("long start");
c_wrap: cover property (acc && last);
c_start: cover property (calib_start);
c_part: cover property (acc && vec_index == 10'h004);
endmodule // lpcal_checker
bind lpcal_sched lpcal_checker #(.VEC_LEN(VEC_LEN)) i_chk (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .vec_rdata(vec_rdata),
    .vec_index(vec_index), .vec_we(vec_we), .vec_wdata(vec_wdata),
    .vec_valid(vec_valid), .calib_start(calib_start));
`default_nettype wire

// ===== lpcal_vec_store.sv
// Purpose: vector store beside lpcal_sched
// Assumes: byte at index read combinationally
// Notes: preloaded pattern
`timescale 1ns/1ps
`default_nettype none
module lpcal_vec_store (
    input wire logic clk_sys,
    input wire logic [9:0] vec_index,
    input wire logic vec_we,
    input wire logic [7:0] vec_wdata,
    output logic [7:0] vec_rdata
);
logic [7:0] mem [0:1023];
initial for (int i = 0; i < 1024; i++) mem[i] = 8'(i) ^ 8'h5A;
assign vec_rdata = mem[vec_index];
always @(posedge clk_sys) begin
    if (vec_we) mem[vec_index] <= vec_wdata;
end
endmodule // lpcal_vec_store
`default_nettype wire

// ===== lowpower_cal_sched_and_cal_vector_port_tb.sv
// Purpose: register-level bench for lpcal_sched
// Assumes: calibration halted until the second status read, before the scheduler runs
// Notes: code 0 delays give 2304 cycles
`timescale 1ns/1ps
`default_nettype none
module lowpower_cal_sched_and_cal_vector_port_tb;
logic clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, calib_halted = 1;
logic background_calib_enable = 0, calib_trigger_pin = 1;
logic [6:0] reg_addr = 0;
logic [7:0] reg_wdata = 0, reg_rdata, vec_rdata, vec_wdata;
logic [9:0] vec_index;
logic vec_we, vec_valid, core_sleep, core_settling, calib_start;
int n_mismatch = 0, n_compared = 0, cyc = 0, i, n;
always #50 clk_sys = ~clk_sys;
lpcal_sched i_dut (.clk_sys, .sys_rst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .background_calib_enable, .calib_halted,
    .calib_trigger_pin, .vec_rdata, .vec_index, .vec_we, .vec_wdata,
    .vec_valid, .core_sleep, .core_settling, .calib_start);
lpcal_vec_store i_store (.clk_sys, .vec_index, .vec_we, .vec_wdata,
    .vec_rdata);
task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
        n_mismatch++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1;
    reg_wr = w; reg_rd = !w; reg_addr = a; reg_wdata = d;
endtask
task rd(input logic [6:0] a, input logic [7:0] e);
    acc(0, a, 8'h00); #50 chk(reg_rdata, e);
endtask
task idle;
    @(posedge clk_sys) #1 reg_wr = 0; reg_rd = 0;
endtask
task waitfor(input logic v, input int lim);
    n = 0;
    while ((core_sleep | core_settling) !== v && n < lim) begin
        @(posedge clk_sys) #1 n++;
    end
endtask
task phase(input logic s);
    n = 0;
    while ((s ? core_sleep : core_settling) === 1'b1 && n < 5000) begin
        @(posedge clk_sys) #1 n++;
    end
endtask
task summarize;
    $display("mismatches=%0d compared=%0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask
always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
        n_mismatch++;
        summarize;
    end
end
initial begin
    repeat (20) @(posedge clk_sys);
    #1 sys_rst = 0;
    rd(7'h6E, 8'h88);
    rd(7'h6A, 8'h02);
    rd(7'h70, 8'h00);
    acc(1, 7'h71, 8'hAA); rd(7'h71, 8'h00);
    rd(7'h7F, 8'h00);
    acc(1, 7'h70, 8'h01); rd(7'h70, 8'h01);
    idle; chk(vec_index, 0);
    for (i = 0; i < 673; i++) rd(7'h71, 8'(i) ^ 8'h5A);
    idle; chk({vec_valid, vec_index}, 16'h0400);
    for (i = 0; i < 673; i++) acc(1, 7'h71, 8'(i * 3 + 1));
    for (i = 0; i < 673; i++) rd(7'h71, 8'(i * 3 + 1));
    for (i = 0; i < 5; i++) rd(7'h71, 8'(i * 3 + 1));
    idle; chk(vec_valid, 0);
    acc(1, 7'h70, 8'h01); idle; chk(vec_index, 0);
    rd(7'h71, 8'h01);
    idle;
    sys_rst = 1;
    repeat (2) @(posedge clk_sys);
    #1 sys_rst = 0;
    chk({vec_valid, vec_index}, 16'h0400);
    rd(7'h70, 8'h00);
    idle;
    calib_halted = 0;
    rd(7'h6A, 8'h00);
    idle;
    background_calib_enable = 1;
    acc(1, 7'h6E, 8'h01); idle;
    waitfor(1, 10);
    for (i = 0; i < 2; i++) begin
        phase(1); chk(n, 2304);
        phase(0); chk(n, 2304);
        chk(calib_start, 1);
        n = 0;
        while (!core_sleep && n < 10) begin @(posedge clk_sys) #1 n++; end
    end
    acc(1, 7'h6B, 8'h01); acc(1, 7'h6E, 8'h03); idle;
    repeat (3000) @(posedge clk_sys);
    #1 chk(core_sleep, 1);
    calib_trigger_pin = 0;
    n = 0;
    while (!core_settling && n < 10) begin @(posedge clk_sys) #1 n++; end
    chk(core_settling, 1);
    calib_trigger_pin = 1;
    n = 0;
    while (!core_sleep && n < 3000) begin @(posedge clk_sys) #1 n++; end
    acc(1, 7'h6B, 8'h00);
    idle;
    repeat (10) @(posedge clk_sys);
    #1 chk(core_sleep, 1);
    acc(1, 7'h6C, 8'h00);
    idle;
    n = 0;
    while (!core_settling && n < 10) begin @(posedge clk_sys) #1 n++; end
    chk(core_settling, 1);
    background_calib_enable = 0;
    waitfor(0, 10); chk(core_sleep | core_settling, 0);
    summarize;
end
endmodule // lowpower_cal_sched_and_cal_vector_port_tb
`default_nettype wire
